// ### design/spc_top.sv
`timescale 1ns/1ns
// Overview of operation
// - After a wake-up event stay awake for the hold count, then suspend.
// - Return to suspend only if software has not resumed normal operation.
// - Hold count resets to 03E8h, a 10 ms interval.
// - A hold count of zero never wakes; the device stays suspended.
// - Setting FFFh gives the longest documented wake time, 40.95 ms.
// - Each count unit is one 10 us slow suspend clock period.
// - In 16-bit bus mode the hold count resets to 17E8h.
// - In 16-bit mode any write of the count after the mode capture cycle forces 1400h.
// - Bit 12 set connects the third port pull-downs.
// - Bit 11 set connects the second port pull-downs.
// - Bit 10 controls power to the battery detector.
// - In suspend, bit 10 low powers the detector, high leaves it off.
module spc_top
  import spc_pkg::*;
#(
  parameter int SLOW_DIV = SPC_SLOW_DIV
) (
  input  wire logic            core_clk_in,
  input  wire logic            resetn_in,
  input  wire spc_pkg::spc_req_t req_in,
  input  wire logic            bus16_mode_in,
  input  wire logic            wake_event_in,
  input  wire logic            normal_op_in,
  output logic [31:0]          rdata_out,
  output logic                 rvalid_out,
  output logic                 awake_out,
  output logic                 third_port_pulldown_enable_out,
  output logic                 second_port_pulldown_enable_out,
  output logic                 battery_detector_power_out,
  output logic                 host_core_clock_gate_out
);
  import spc_pkg::*;

  logic [15:0] hold_count;
  logic [15:0] next_hold_count;
  logic [15:0] low_bits;
  logic [15:0] remain;
  logic        mode_s1;
  logic        mode_s2;
  logic        wake_s1;
  logic        wake_s2;
  logic        wake_d;
  logic        norm_s1;
  logic        norm_s2;
  logic        mode_seen;
  logic        slow_tick;
  logic        wake_pulse;
  logic        reg_wr;
  logic        reg_rd;
  spc_state_t  state;

  // Register decode and wake edge
  assign reg_wr     = req_in.wr && (req_in.addr == SPC_REG_OFFSET);
  assign reg_rd     = req_in.rd && (req_in.addr == SPC_REG_OFFSET);
  assign wake_pulse = wake_s2 && !wake_d;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_d  <= 1'b0;
      norm_s1 <= 1'b0;
      norm_s2 <= 1'b0;
    end else begin
      wake_s1 <= wake_event_in;
      wake_s2 <= wake_s1;
      wake_d  <= wake_s2;
      norm_s1 <= normal_op_in;
      norm_s2 <= norm_s1;
    end
  end

  // Bus mode synchroniser runs through reset, so the mode
  // is already settled when the count default is chosen
  always_ff @(posedge core_clk_in) begin
    mode_s1 <= bus16_mode_in;
    mode_s2 <= mode_s1;
  end

  // Restart on a wake edge so the first slow period is a full one
  // slow tick divider
  spc_tick_div #(
    .DIV (SLOW_DIV)
  ) u_div (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .restart_in  (wake_pulse),
    .tick_out    (slow_tick)
  );

  // ==========================================================
  // Count a write would store; 16-bit mode ignores the data
  always_comb begin
    next_hold_count = req_in.wdata[SPC_CNT_LSB +: 16];
    if (mode_s2) begin
      next_hold_count = SPC_CNT_FIXED_16;
    end else if (req_in.wdata[SPC_CNT_LSB +: 16] > SPC_CNT_MAX) begin
      // FFFh is the longest setting, larger data saturates
      next_hold_count = SPC_CNT_MAX;
    end
  end

  // ==========================================================
  // Hold count field; bus mode caught after reset release
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      hold_count <= SPC_CNT_RESET_32;
      mode_seen  <= 1'b0;
    end else if (!mode_seen) begin
      // A count write in this capture cycle is dropped
      mode_seen <= 1'b1;
      if (mode_s2) begin
        hold_count <= SPC_CNT_RESET_16;
      end
    end else if (reg_wr) begin
      hold_count <= next_hold_count;
    end
  end

  // Low half: pull-downs, detector power, clock gate, reserved bits
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      low_bits <= SPC_LOW_RESET;
    end else if (reg_wr) begin
      low_bits <= req_in.wdata[15:0];
    end
  end

  // ==========================================================
  // Wake hold state machine
  // Slow ticks only count down while awake
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state  <= SPC_SUSPENDED;
      remain <= 16'h0000;
    end else begin
      case (state)
        SPC_SUSPENDED: begin
          if (wake_pulse && hold_count != 16'h0000) begin
            state  <= SPC_AWAKE;
            remain <= hold_count;
          end
        end
        SPC_AWAKE: begin
          if (wake_pulse) begin
            remain <= hold_count;
          end else if (norm_s2) begin
            remain <= hold_count;
          end else if (slow_tick) begin
            if (remain <= 16'h0001) begin
              state <= SPC_SUSPENDED;
            end
            remain <= remain - 16'h0001;
          end
        end
        default: state <= SPC_SUSPENDED;
      endcase
    end
  end

  // ==========================================================
  // Read port: answer one cycle after the request
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= 32'h00000000;
    end else begin
      rvalid_out <= req_in.rd;
      // Unmapped offsets read back as zero
      if (reg_rd) begin
        rdata_out <= {hold_count, low_bits};
      end else begin
        rdata_out <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // Awake indication and detector power
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      awake_out                  <= 1'b0;
      battery_detector_power_out <= 1'b0;
    end else begin
      awake_out                  <= (state == SPC_AWAKE) || norm_s2;
      // detector powered unless suspended with bit set
      battery_detector_power_out <= (state == SPC_AWAKE) || norm_s2 || !low_bits[SPC_BAT_BIT];
    end
  end

  // ==========================================================
  // Register bits copied onto the control pins
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      third_port_pulldown_enable_out  <= 1'b0;
      second_port_pulldown_enable_out <= 1'b0;
      host_core_clock_gate_out        <= 1'b0;
    end else begin
      third_port_pulldown_enable_out  <= low_bits[SPC_PD3_BIT];
      second_port_pulldown_enable_out <= low_bits[SPC_PD2_BIT];
      // Clock gate bit only drives this pin
      host_core_clock_gate_out        <= low_bits[SPC_CLKGATE_BIT];
    end
  end
endmodule

// ### design/spc_pkg.sv
package spc_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] SPC_REG_OFFSET      = 12'h354;
  // ==========================================================
  // Field positions
  localparam int          SPC_CNT_LSB         = 16;
  localparam int          SPC_PD3_BIT         = 12;
  localparam int          SPC_PD2_BIT         = 11;
  localparam int          SPC_BAT_BIT         = 10;
  localparam int          SPC_CLKGATE_BIT     = 0;
  // ==========================================================
  // Reset, fixed and maximum count values
  localparam logic [15:0] SPC_CNT_RESET_32    = 16'h03E8;
  localparam logic [15:0] SPC_CNT_RESET_16    = 16'h17E8;
  localparam logic [15:0] SPC_CNT_FIXED_16    = 16'h1400;
  localparam logic [15:0] SPC_CNT_MAX         = 16'h0FFF;
  localparam logic [15:0] SPC_LOW_RESET       = 16'h1BA0;
  // ==========================================================
  // Timing: slow suspend clock period from the core clock
  localparam int          SPC_CORE_CLK_HZ     = 50_000_000;
  localparam int          SPC_SLOW_PERIOD_US  = 10;
  localparam int          SPC_SLOW_DIV        = SPC_CORE_CLK_HZ / 1_000_000 * SPC_SLOW_PERIOD_US;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } spc_req_t;

  typedef enum {SPC_SUSPENDED, SPC_AWAKE} spc_state_t;
endpackage

// ### design/spc_tick_div.sv
`timescale 1ns/1ns
// One-cycle enable pulse every DIV core cycles
module spc_tick_div #(
  parameter int DIV = 500
) (
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic restart_in,
  output logic      tick_out
);
  logic [15:0] cnt;

  // ==========================================================
  // Divider
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || restart_in) begin
      cnt      <= 16'h0000;
      tick_out <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt      <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      cnt      <= cnt + 16'h0001;
      tick_out <= 1'b0;
    end
  end
endmodule

// ### verification/spc_sva.sv
`timescale 1ns/1ns
// ==========================================
// Port checker for the suspend power block
module spc_sva
  import spc_pkg::*;
(
  input wire logic             core_clk_in,
  input wire logic             resetn_in,
  input wire spc_pkg::spc_req_t req_in,
  input wire logic             bus16_mode_in,
  input wire logic             wake_event_in,
  input wire logic             normal_op_in,
  input wire logic [31:0]      rdata_out,
  input wire logic             rvalid_out,
  input wire logic             awake_out,
  input wire logic             third_port_pulldown_enable_out,
  input wire logic             second_port_pulldown_enable_out,
  input wire logic             battery_detector_power_out,
  input wire logic             host_core_clock_gate_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic hit;
  // Write to this register; the properties add that reset was released a cycle earlier
  assign hit = req_in.wr && req_in.addr == SPC_REG_OFFSET;
  property p_rv; req_in.rd && req_in.addr == SPC_REG_OFFSET |=> rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_rvone; rvalid_out |-> $past(req_in.rd); endproperty
  a_rvone: assert property (p_rvone) else $error("stray read answer");
  property p_oth; rvalid_out && $past(req_in.addr) != SPC_REG_OFFSET |-> rdata_out == 32'h0; endproperty
  a_oth: assert property (p_oth) else $error("unmapped read not zero");
  property p_pd3; hit && $past(resetn_in) |=> ##1 third_port_pulldown_enable_out == $past(req_in.wdata[12], 2); endproperty
  a_pd3: assert property (p_pd3) else $error("third pull-down wrong");
  property p_pd2; hit && $past(resetn_in) |=> ##1 second_port_pulldown_enable_out == $past(req_in.wdata[11], 2); endproperty
  a_pd2: assert property (p_pd2) else $error("second pull-down wrong");
  property p_gate; hit && $past(resetn_in) |=> ##1 host_core_clock_gate_out == $past(req_in.wdata[0], 2); endproperty
  a_gate: assert property (p_gate) else $error("clock gate wrong");
  property p_bat; !battery_detector_power_out |-> !awake_out; endproperty
  a_bat: assert property (p_bat) else $error("detector off while awake");
  property p_batw; hit && $past(resetn_in) && !req_in.wdata[10] |=> ##1 battery_detector_power_out; endproperty
  a_batw: assert property (p_batw) else $error("detector off with bit clear");
  c_rd: cover property (rvalid_out);
  c_wake: cover property ($rose(awake_out));
  c_off: cover property (!battery_detector_power_out);
endmodule
bind spc_top spc_sva i_sva (.*);

// ### verification/testbench.sv
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the suspend power block
module testbench;
  import spc_pkg::*;
  logic clk = 0, rstn = 0, b16 = 0, wk = 0, nop = 0, rv, aw, p3, p2, bat, cg;
  logic [31:0] rdat;
  spc_req_t req = '0;
  int n_errors = 0, n_checks = 0, cnt;
  initial forever #10 clk = ~clk;
  spc_top #(.SLOW_DIV(5)) i_dut (.core_clk_in(clk), .resetn_in(rstn), .req_in(req), .bus16_mode_in(b16),
    .wake_event_in(wk), .normal_op_in(nop), .rdata_out(rdat), .rvalid_out(rv), .awake_out(aw),
    .third_port_pulldown_enable_out(p3), .second_port_pulldown_enable_out(p2),
    .battery_detector_power_out(bat), .host_core_clock_gate_out(cg));
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task rst(input logic m, input int n);
    b16 = m; rstn = 0;
    repeat (n) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
  endtask
  // callers keep reserved bits at their reset values
  task wr(input logic [31:0] d);
    @(negedge clk); req.wr = 1; req.addr = SPC_REG_OFFSET; req.wdata = d;
    @(negedge clk); req.wr = 0;
    repeat (2) @(negedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge clk); req.rd = 1; req.addr = a;
    @(negedge clk); req.rd = 0;
    chk({31'h0, rv}, 32'h1);
    chk(rdat, e);
  endtask
  task pulse;
    @(negedge clk); wk = 1;
    repeat (3) @(negedge clk);
    wk = 0;
  endtask
  // Bounded wait for the awake level, counting cycles
  task waitaw(input logic lvl, input int lim);
    cnt = 0;
    while (aw !== lvl && cnt < lim) begin @(negedge clk); cnt++; end
    if (aw !== lvl) begin chk(0, 1); results; end
  endtask
  task t_regs;
    rd(12'h354, 32'h03E81BA0);
    chk({p3, p2, cg}, 3'b110);
    wr(32'h03E80BA1);
    chk({p3, p2, cg}, 3'b011);
    wr(32'h03E813A0);
    chk({p3, p2, cg}, 3'b100);
    wr(32'hFFFF1BA0);
    rd(12'h354, 32'h0FFF1BA0);
    rd(12'h350, 32'h0);
    $display("register test done");
  endtask
  task t_wake(input logic [15:0] n);
    wr({n, 16'h1FA0});
    chk(bat, 1'b0);
    pulse;
    waitaw(1, 20);
    chk(bat, 1'b1);
    waitaw(0, 30000);
    chk(cnt >= (n - 1) * 5 && cnt <= n * 5 + 10, 1'b1);
    $display("wake test done");
  endtask
  task t_other;
    wr(32'h00001BA0);
    pulse;
    repeat (40) @(negedge clk);
    chk(aw, 1'b0);
    wr(32'h00041BA0); nop = 1;
    pulse;
    repeat (60) @(negedge clk);
    chk(aw, 1'b1);
    nop = 0;
    repeat (10) @(negedge clk);
    chk(aw, 1'b1);
    waitaw(0, 60);
    rst(1, 4);
    rd(12'h354, 32'h17E81BA0);
    wr(32'hABCD1BA0);
    rd(12'h354, 32'h14001BA0);
    rst(0, 4);
    rd(12'h354, 32'h03E81BA0);
    $display("zero, normal and 16-bit tests done");
  endtask
  initial begin
    rst(0, 2);
    t_regs;
    t_wake(16'h0004);
    t_wake(16'h0FFF);
    t_other;
    results;
  end
endmodule
